/* pkg/fmsp_regs.svh */
// Register indices, field positions, reset values and timing counts
`ifndef FMSP_REGS_SVH
`define FMSP_REGS_SVH

`define FMSP_IDX_CTRL_HIGH   8'hee
`define FMSP_IDX_CTRL_LOW    8'hef
`define FMSP_IDX_DATA_BUF    8'hf0
`define FMSP_IDX_BAUD_DIV    8'hf1

`define FMSP_CTRL_HIGH_RESET 8'h00
`define FMSP_CTRL_LOW_RESET  8'h00
`define FMSP_BAUD_DIV_RESET  8'h00

`define FMSP_H_MODE_HI       7
`define FMSP_H_MODE_LO       6
`define FMSP_H_MCE           5
`define FMSP_H_REN           4
`define FMSP_H_TB8           3
`define FMSP_H_RB8           2
`define FMSP_H_RIE           1
`define FMSP_H_RIP           0

`define FMSP_L_PAR_AUTO      7
`define FMSP_L_TX_ODD        6
`define FMSP_L_RX_ODD        5
`define FMSP_L_PAR_ERR       4
`define FMSP_L_CLK_HI        3
`define FMSP_L_CLK_LO        2
`define FMSP_L_TIE           1
`define FMSP_L_TIP           0

`define FMSP_OVERSAMPLE      16
`define FMSP_HALF_BIT        8

`endif

/* pkg/fmsp_pkg.sv */
// Types shared by the four-mode serial port
package fmsp_pkg;

    typedef enum logic [1:0] {
        FMSP_MODE_SHIFT = 2'b00,
        FMSP_MODE_UART8 = 2'b01,
        FMSP_MODE_FIX9  = 2'b10,
        FMSP_MODE_VAR9  = 2'b11
    } fmsp_mode_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fmsp_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fmsp_apb_rsp_t;

endpackage

/* verilog/fmsp_serial_port.sv */
// Four-mode serial port with APB register access
//
// Behaviour
// RQ1 - Bits 7:6 of high control select shift, 8-bit, 9-bit fixed, 9-bit variable
// RQ2 - Modes 0, 1, 3 run at source clock / (16 x (divisor + 1))
// RQ3 - Mode 2 runs at source clock / 16, divisor ignored
// RQ4 - Data address writes transmit buffer, reads separate receive buffer
// RQ5 - Next byte may arrive while previous unread; unread byte is lost
// RQ6 - Any write to the data register starts a transmission; the code ignores the write unless the transmitter is idle
// RQ7 - Mode 0 receive starts when receive pending is 0 and enable is 1
// RQ8 - Async modes start receiving on a low start bit when enabled
// RQ9 - Finished shift sets pending flag and interrupt gated by enable
// RQ10 - High bit 1 enables receive interrupt, low bit 1 transmit interrupt
// RQ11 - Bit 0 of each control register is pending; writing 0 clears it
// RQ12 - Reset zeroes both control registers
// RQ13 - Multiprocessor enable in modes 2, 3 suppresses interrupt if ninth bit 0
// RQ14 - Multiprocessor enable in mode 1 withholds interrupt without valid stop
// RQ15 - Without autoparity, high bit 3 is the ninth transmitted bit
// RQ16 - Without autoparity, ninth received bit stored in high bit 2
// RQ17 - Low bit 7 makes the ninth transmitted bit an automatic parity bit
// RQ18 - Low bit 6 selects transmit parity: 0 even, 1 odd
// RQ19 - Low bit 5 selects checked receive parity: 0 even, 1 odd
// RQ20 - Low bit 4 flags a parity failure in modes 2, 3, else 0
// RQ21 - Low bits 3:2 pick source clock system / 8, 4, 2, 1
// RQ22 - High bit 4 enables reception
// RQ23 - Receive pending sets after bit 8, mid stop, or mid ninth bit
// RQ24 - Transmit pending sets after bit 8 in mode 0, at stop start else
// RQ25 - Mode 1 frame: start, eight data LSB first, stop
// RQ26 - Modes 2, 3 frame: start, eight data, ninth bit, ignored stop
// RQ27 - Async receiver samples each bit at its centre via x16 clock
// RQ28 - Mode 0 drives shift clock on transmit pin, data LSB first on receive
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "fmsp_regs.svh"

module fmsp_serial_port
    import fmsp_pkg::*;
(
    input  wire logic          clk_sys,      // System clock, 200 MHz
    input  wire logic          reset,        // Synchronous reset, high
    input  wire fmsp_apb_req_t apb_req,      // APB request group
    output fmsp_apb_rsp_t      apb_rsp,      // APB answer group
    output logic               txd_out,      // Transmit pin level
    input  wire logic          rxd_in,       // Receive pin level
    output logic               rxd_out,      // Receive pin drive, mode 0
    output logic               rxd_oe,       // Receive pin drive enable
    output logic               rx_irq,       // Receive interrupt request
    output logic               tx_irq        // Transmit interrupt request
);

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP, TX_SHIFT}
        fmsp_tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP}
        fmsp_rx_state_t;

    logic [7:0]     ctrl_high_r;
    logic [7:0]     ctrl_low_r;
    logic [7:0]     baud_div_r;
    logic [7:0]     rx_buf_r;
    logic [7:0]     tx_shift_r;
    logic [7:0]     rx_shift_r;
    logic [7:0]     rx_async_r;
    logic [2:0]     presc_cnt_r;
    logic           src_tick_r;
    logic [7:0]     baud_cnt_r;
    logic           tick16_r;
    fmsp_tx_state_t tx_state_r;
    logic [3:0]     tx_sub_r;
    logic [2:0]     tx_bit_r;
    logic           tx_ninth_r;
    logic           sh_is_rx_r;
    fmsp_rx_state_t rx_state_r;
    logic [3:0]     rx_sub_r;
    logic [2:0]     rx_bit_r;
    logic           rx_ninth_r;
    logic           pready_r;
    logic           pslverr_r;
    logic [31:0]    prdata_r;

    fmsp_mode_t     mode;
    logic           async9;
    logic           par_auto;
    logic [2:0]     presc_last;
    logic [7:0]     div_eff;
    logic           access;
    logic [9:0]     reg_idx;
    logic           wr_high;
    logic           wr_low;
    logic           wr_data;
    logic           wr_div;
    logic           mapped;
    logic           tx_done;
    logic           rx_done;
    logic           rx_set;
    logic           rx_par_bad;
    logic           sh_rise;
    logic           sh_last;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign mode = fmsp_mode_t'(ctrl_high_r[`FMSP_H_MODE_HI:`FMSP_H_MODE_LO]); // RQ1
    assign async9   = mode == FMSP_MODE_FIX9 || mode == FMSP_MODE_VAR9;
    assign par_auto = ctrl_low_r[`FMSP_L_PAR_AUTO];
    assign access   = apb_req.psel && apb_req.penable && !pready_r;
    assign reg_idx  = apb_req.paddr[11:2];
    assign wr_high  = access && apb_req.pwrite
                      && reg_idx == {2'b00, `FMSP_IDX_CTRL_HIGH};
    assign wr_low   = access && apb_req.pwrite
                      && reg_idx == {2'b00, `FMSP_IDX_CTRL_LOW};
    assign wr_data  = access && apb_req.pwrite
                      && reg_idx == {2'b00, `FMSP_IDX_DATA_BUF};
    assign wr_div   = access && apb_req.pwrite
                      && reg_idx == {2'b00, `FMSP_IDX_BAUD_DIV};
    assign mapped   = apb_req.paddr[1:0] == 2'b00
                      && (reg_idx == {2'b00, `FMSP_IDX_CTRL_HIGH}
                       || reg_idx == {2'b00, `FMSP_IDX_CTRL_LOW}
                       || reg_idx == {2'b00, `FMSP_IDX_DATA_BUF}
                       || reg_idx == {2'b00, `FMSP_IDX_BAUD_DIV});

    // ------------------------------------------------------------------
    // Source clock prescaler and x16 baud tick
    // ------------------------------------------------------------------
    always_comb begin
        case (ctrl_low_r[`FMSP_L_CLK_HI:`FMSP_L_CLK_LO]) // RQ21
            2'b00:   presc_last = 3'h7;
            2'b01:   presc_last = 3'h3;
            2'b10:   presc_last = 3'h1;
            default: presc_last = 3'h0;
        endcase
    end

    assign div_eff = (mode == FMSP_MODE_FIX9) ? 8'h00 : baud_div_r; // RQ2 RQ3

    always_ff @(posedge clk_sys) begin
        if (reset || presc_cnt_r >= presc_last) begin
            presc_cnt_r <= 3'h0;
            src_tick_r  <= !reset;
        end else begin
            presc_cnt_r <= presc_cnt_r + 3'h1;
            src_tick_r  <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            baud_cnt_r <= 8'h00;
            tick16_r   <= 1'b0;
        end else if (src_tick_r) begin
            if (baud_cnt_r >= div_eff) begin
                baud_cnt_r <= 8'h00;
                tick16_r   <= 1'b1;
            end else begin
                baud_cnt_r <= baud_cnt_r + 8'h01;
                tick16_r   <= 1'b0;
            end
        end else begin
            tick16_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter and mode 0 shift engine
    // ------------------------------------------------------------------
    assign sh_rise = tick16_r && tx_sub_r == 4'(`FMSP_HALF_BIT - 1);
    assign sh_last = tick16_r && tx_sub_r == 4'(`FMSP_OVERSAMPLE - 1);
    assign tx_done = (tx_state_r == TX_SHIFT && !sh_is_rx_r && sh_last
                      && tx_bit_r == 3'h7)
                  || (tx_state_r == TX_NINTH && sh_last)
                  || (tx_state_r == TX_DATA && sh_last && tx_bit_r == 3'h7
                      && !async9); // RQ24

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_state_r <= TX_IDLE;
            tx_sub_r   <= 4'h0;
            tx_bit_r   <= 3'h0;
            tx_shift_r <= 8'h00;
            tx_ninth_r <= 1'b0;
            sh_is_rx_r <= 1'b0;
            rx_shift_r <= 8'h00;
        end else if (wr_data && tx_state_r == TX_IDLE) begin // RQ4 RQ6
            tx_shift_r <= apb_req.pwdata[7:0];
            tx_ninth_r <= par_auto                                  // RQ17
                ? ^apb_req.pwdata[7:0] ^ ctrl_low_r[`FMSP_L_TX_ODD] // RQ18
                : ctrl_high_r[`FMSP_H_TB8];                         // RQ15
            tx_sub_r   <= 4'h0;
            tx_bit_r   <= 3'h0;
            sh_is_rx_r <= 1'b0;
            tx_state_r <= (mode == FMSP_MODE_SHIFT) ? TX_SHIFT : TX_START;
        end else if (tx_state_r == TX_IDLE && mode == FMSP_MODE_SHIFT
                     && !ctrl_high_r[`FMSP_H_RIP]
                     && ctrl_high_r[`FMSP_H_REN]) begin // RQ7
            tx_sub_r   <= 4'h0;
            tx_bit_r   <= 3'h0;
            sh_is_rx_r <= 1'b1;
            tx_state_r <= TX_SHIFT;
        end else if (tick16_r && tx_state_r != TX_IDLE) begin
            tx_sub_r <= tx_sub_r + 4'h1;
            if (sh_rise && sh_is_rx_r) begin
                rx_shift_r <= {rxd_in, rx_shift_r[7:1]}; // RQ28
            end
            if (sh_last) begin
                tx_bit_r <= tx_bit_r + 3'h1;
                case (tx_state_r)
                    TX_START: begin
                        tx_bit_r   <= 3'h0;
                        tx_state_r <= TX_DATA; // RQ25
                    end
                    TX_DATA: begin
                        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        if (tx_bit_r == 3'h7) begin
                            tx_state_r <= async9 ? TX_NINTH : TX_STOP; // RQ26
                        end
                    end
                    TX_NINTH: tx_state_r <= TX_STOP;
                    TX_SHIFT: begin
                        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        if (tx_bit_r == 3'h7) begin
                            tx_state_r <= TX_IDLE;
                        end
                    end
                    default: tx_state_r <= TX_IDLE;
                endcase
            end
        end
    end

    // Pin drivers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txd_out <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe  <= 1'b0;
        end else begin
            case (tx_state_r)
                TX_START: txd_out <= 1'b0;
                TX_DATA:  txd_out <= tx_shift_r[0];
                TX_NINTH: txd_out <= tx_ninth_r;
                TX_SHIFT: txd_out <= tx_sub_r >= 4'(`FMSP_HALF_BIT); // RQ28
                default:  txd_out <= 1'b1;
            endcase
            rxd_oe  <= tx_state_r == TX_SHIFT && !sh_is_rx_r;
            rxd_out <= (tx_state_r == TX_SHIFT) ? tx_shift_r[0] : 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Asynchronous receiver
    // ------------------------------------------------------------------
    assign rx_done    = (tx_state_r == TX_SHIFT && sh_is_rx_r && sh_last
                         && tx_bit_r == 3'h7)
                     || (tick16_r && rx_sub_r == 4'(`FMSP_OVERSAMPLE - 1)
                         && ((rx_state_r == RX_STOP && !async9)
                          || rx_state_r == RX_NINTH)); // RQ23
    assign rx_par_bad = (^rx_async_r ^ rxd_in)
                        != ctrl_low_r[`FMSP_L_RX_ODD]; // RQ19
    always_comb begin
        rx_set = rx_done;
        if (mode == FMSP_MODE_UART8 && ctrl_high_r[`FMSP_H_MCE] && !rxd_in) begin
            rx_set = 1'b0; // RQ14
        end
        if (async9 && ctrl_high_r[`FMSP_H_MCE] && !rxd_in) begin
            rx_set = 1'b0; // RQ13
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_state_r <= RX_IDLE;
            rx_sub_r   <= 4'h0;
            rx_bit_r   <= 3'h0;
            rx_ninth_r <= 1'b0;
        end else if (mode == FMSP_MODE_SHIFT) begin
            rx_state_r <= RX_IDLE;
        end else if (rx_state_r == RX_IDLE) begin
            rx_sub_r <= 4'h0;
            rx_bit_r <= 3'h0;
            if (!rxd_in && ctrl_high_r[`FMSP_H_REN]) begin // RQ8 RQ22
                rx_state_r <= RX_START;
            end
        end else if (tick16_r) begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_state_r == RX_START
                && rx_sub_r == 4'(`FMSP_HALF_BIT - 1)) begin // RQ27
                rx_sub_r   <= 4'h0;
                rx_state_r <= rxd_in ? RX_IDLE : RX_DATA;
            end else if (rx_sub_r == 4'(`FMSP_OVERSAMPLE - 1)) begin
                case (rx_state_r)
                    RX_DATA: begin
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == 3'h7) begin
                            rx_state_r <= async9 ? RX_NINTH : RX_STOP;
                        end
                    end
                    RX_NINTH: begin
                        rx_ninth_r <= rxd_in;
                        rx_state_r <= RX_STOP;
                    end
                    default: rx_state_r <= RX_IDLE;
                endcase
            end
        end
    end

    // Async data bits shift into the receive shifter
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_async_r <= 8'h00;
        end else if (tick16_r && rx_state_r == RX_DATA
                     && rx_sub_r == 4'(`FMSP_OVERSAMPLE - 1)) begin
            rx_async_r <= {rxd_in, rx_async_r[7:1]}; // RQ25
        end
    end

    // Later byte overwrites an unread one
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_buf_r <= 8'h00;
        end else if (rx_set) begin
            rx_buf_r <= (mode == FMSP_MODE_SHIFT)
                ? {rxd_in, rx_shift_r[7:1]} : rx_async_r; // RQ5
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_high_r <= `FMSP_CTRL_HIGH_RESET; // RQ12
        end else begin
            if (wr_high) begin
                ctrl_high_r <= apb_req.pwdata[7:0];
            end
            if (rx_done && async9 && !par_auto) begin
                ctrl_high_r[`FMSP_H_RB8] <= rxd_in; // RQ16
            end
            if (rx_set) begin
                ctrl_high_r[`FMSP_H_RIP] <= 1'b1; // RQ9 RQ11
            end else if (wr_high) begin
                ctrl_high_r[`FMSP_H_RIP] <= apb_req.pwdata[`FMSP_H_RIP]; // RQ11
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_low_r <= `FMSP_CTRL_LOW_RESET; // RQ12
        end else begin
            if (wr_low) begin
                ctrl_low_r[7:5] <= apb_req.pwdata[7:5];
                ctrl_low_r[3:1] <= apb_req.pwdata[3:1];
            end
            if (rx_done && async9) begin
                ctrl_low_r[`FMSP_L_PAR_ERR] <= par_auto && rx_par_bad; // RQ20
            end else if (!async9) begin
                ctrl_low_r[`FMSP_L_PAR_ERR] <= 1'b0; // RQ20
            end
            if (tx_done) begin
                ctrl_low_r[`FMSP_L_TIP] <= 1'b1; // RQ9 RQ24
            end else if (wr_low) begin
                ctrl_low_r[`FMSP_L_TIP] <= apb_req.pwdata[`FMSP_L_TIP]; // RQ11
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            baud_div_r <= `FMSP_BAUD_DIV_RESET;
        end else if (wr_div) begin
            baud_div_r <= apb_req.pwdata[7:0];
        end
    end

    // Interrupt request levels
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            rx_irq <= ctrl_high_r[`FMSP_H_RIP] && ctrl_high_r[`FMSP_H_RIE]; // RQ10
            tx_irq <= ctrl_low_r[`FMSP_L_TIP] && ctrl_low_r[`FMSP_L_TIE]; // RQ10
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, registered answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= access;
            pslverr_r <= access && !mapped;
            prdata_r  <= 32'h0000_0000;
            if (access && !apb_req.pwrite) begin
                if (reg_idx == {2'b00, `FMSP_IDX_CTRL_HIGH}) begin
                    prdata_r <= {24'h000000, ctrl_high_r};
                end else if (reg_idx == {2'b00, `FMSP_IDX_CTRL_LOW}) begin
                    prdata_r <= {24'h000000, ctrl_low_r};
                end else if (reg_idx == {2'b00, `FMSP_IDX_DATA_BUF}) begin
                    prdata_r <= {24'h000000, rx_buf_r}; // RQ4
                end else if (reg_idx == {2'b00, `FMSP_IDX_BAUD_DIV}) begin
                    prdata_r <= {24'h000000, baud_div_r};
                end
            end
        end
    end

    assign apb_rsp = '{pready: pready_r, pslverr: pslverr_r,
                       prdata: prdata_r};

endmodule

/* verification/fmsp_serial_port_monitor.sv */
// Port checker for the four-mode serial port
`timescale 1ns/1ps
`include "fmsp_regs.svh"
module fmsp_serial_port_monitor
    import fmsp_pkg::*;
(
    input wire logic     clk_sys, // System clock
    input wire logic     reset,   // Synchronous reset
    input fmsp_apb_req_t apb_req, // APB request
    input fmsp_apb_rsp_t apb_rsp, // APB answer
    input wire logic     txd_out, // Transmit pin
    input wire logic     rx_irq,  // Receive request
    input wire logic     tx_irq   // Transmit request
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [11:0] a;
    logic        hit;
    assign a   = apb_req.paddr;
    assign hit = a == {2'b00, `FMSP_IDX_CTRL_HIGH, 2'b00} ||
                 a == {2'b00, `FMSP_IDX_CTRL_LOW, 2'b00} ||
                 a == {2'b00, `FMSP_IDX_DATA_BUF, 2'b00} ||
                 a == {2'b00, `FMSP_IDX_BAUD_DIV, 2'b00};
    // ----
    // Access steps
    // ----
    sequence acc_start;
        apb_req.psel && apb_req.penable && !$past(apb_req.penable);
    endsequence
    sequence wr_clr(ad, b);
        apb_rsp.pready && apb_req.pwrite && a == ad && !apb_req.pwdata[b];
    endsequence
    ready_wait_a: assert property (acc_start |->
        !apb_rsp.pready ##1 apb_rsp.pready) else $error("late ready");
    ready_pulse_a: assert property (apb_rsp.pready |=>
        !apb_rsp.pready) else $error("ready too long");
    bad_addr_a: assert property (apb_rsp.pready && !hit |->
        apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("bad addr");
    good_addr_a: assert property (apb_rsp.pready && hit |->
        !apb_rsp.pslverr && apb_rsp.prdata[31:8] == 24'h0)
        else $error("good addr");
    rx_irq_off_a: assert property (wr_clr(12'h3b8, 1) |->
        ##[0:2] !rx_irq) else $error("rx irq not masked");
    tx_irq_off_a: assert property (wr_clr(12'h3bc, 1) |->
        ##[0:2] !tx_irq) else $error("tx irq not masked");
    tx_stop_a: assert property ($rose(tx_irq) &&
        !$past(apb_rsp.pready) |-> txd_out) else $error("tx irq off stop");
    reset_idle_a: assert property ($fell(reset) |->
        txd_out && !rx_irq && !tx_irq) else $error("reset state");
endmodule

bind fmsp_serial_port fmsp_serial_port_monitor i_fmsp_serial_port_monitor (
    .clk_sys(clk_sys), .reset(reset), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .txd_out(txd_out), .rx_irq(rx_irq), .tx_irq(tx_irq));

/* verification/fmsp_remote_model.sv */
// Remote serial device on the transmit and receive pins
`timescale 1ns/1ps
module fmsp_remote_model #(
    parameter int PERIOD = 32 // Bit period in system clocks
) (
    input wire logic       clk_sys,  // System clock
    input wire logic       txd,      // Line from the port
    input wire logic [3:0] nbits,    // Data bits a frame
    output logic           rxd,      // Line into the port
    output logic [9:0]     got_word, // Stop bit and data seen
    output logic           got_valid // One-cycle capture strobe
);
    // ----
    // Capture, sampled at bit centres
    // ----
    initial begin
        logic [9:0] w;
        rxd       = 1'b1;
        got_word  = 10'h0;
        got_valid = 1'b0;
        forever begin
            @(negedge txd);
            repeat (PERIOD / 2) @(posedge clk_sys);
            if (txd === 1'b0) begin
                w = 10'h0;
                for (int i = 0; i < nbits; i++) begin
                    repeat (PERIOD) @(posedge clk_sys);
                    w[i] = txd;
                end
                repeat (PERIOD) @(posedge clk_sys);
                w[9] = txd;
                got_word  <= w;
                got_valid <= 1'b1;
                @(posedge clk_sys);
                got_valid <= 1'b0;
            end
        end
    end
    // Start low, data first bit first, stop high
    task automatic send(input logic [8:0] w);
        @(posedge clk_sys);
        rxd <= 1'b0;
        for (int i = 0; i <= nbits; i++) begin
            repeat (PERIOD) @(posedge clk_sys);
            rxd <= (i == nbits) ? 1'b1 : w[i];
        end
        repeat (PERIOD) @(posedge clk_sys);
    endtask
endmodule

/* verification/test_fmsp_serial_port.sv */
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
`include "fmsp_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_fmsp_serial_port
    import fmsp_pkg::*;
;
    localparam logic [11:0] A_H = {2'b00, `FMSP_IDX_CTRL_HIGH, 2'b00};
    localparam logic [11:0] A_L = {2'b00, `FMSP_IDX_CTRL_LOW, 2'b00};
    localparam logic [11:0] A_D = {2'b00, `FMSP_IDX_DATA_BUF, 2'b00};
    localparam logic [11:0] A_B = {2'b00, `FMSP_IDX_BAUD_DIV, 2'b00};
    logic          clk_sys, reset, rxd_m, rxd_in, txd_out, rxd_out, rxd_oe;
    logic          rx_irq, tx_irq, got_valid;
    logic [9:0]    got_word, e_tx;
    logic [3:0]    nbits;
    logic [32:0]   e_rd;
    logic [32:0]   rd_q[$];
    logic [9:0]    tx_q[$];
    fmsp_apb_req_t apb_req;
    fmsp_apb_rsp_t apb_rsp;
    int            num_errors, checked;
    assign rxd_in = rxd_oe ? rxd_out : rxd_m;
    fmsp_serial_port i_fmsp_serial_port (.clk_sys(clk_sys), .reset(reset),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .txd_out(txd_out),
        .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
        .rx_irq(rx_irq), .tx_irq(tx_irq));
    fmsp_remote_model i_fmsp_remote_model (.clk_sys(clk_sys),
        .txd(txd_out), .nbits(nbits), .rxd(rxd_m), .got_word(got_word),
        .got_valid(got_valid));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        if (rd_q.size() != 0 || tx_q.size() != 0) num_errors++;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                     pwdata: d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        if (apb_rsp.pready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_hi(input logic rx);
        int n;
        n = 0;
        while ((rx ? rx_irq : tx_irq) !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 2000) begin
            num_errors++;
            print_verdict();
        end
    endtask
    // ----
    // Result watcher
    // ----
    always @(posedge clk_sys) begin
        if (apb_rsp.pready === 1'b1 && apb_req.pwrite === 1'b0) begin
            e_rd = rd_q.size() > 0 ? rd_q.pop_front() : 33'h1;
            `CHK("read", e_rd, {apb_rsp.pslverr, apb_rsp.prdata})
        end
        if (got_valid === 1'b1) begin
            e_tx = tx_q.size() > 0 ? tx_q.pop_front() : ~got_word;
            `CHK("frame", e_tx, got_word)
        end
    end
    initial begin
        logic [7:0] b, c;
        logic       odd, auto;
        reset   = 1'b1;
        apb_req = '0;
        nbits   = 4'd8;
        num_errors = 0;
        checked    = 0;
        void'($urandom(32'h1386));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rd(A_H, 33'h0);
        rd(A_L, 33'h0);
        rd(12'h3c8, {1'b1, 32'h0});
        wr(A_B, 32'h1);
        wr(A_L, 32'h0e);
        wr(A_H, 32'h52);
        b = $urandom;
        tx_q.push_back({2'b10, b});
        wr(A_D, {24'h0, b});
        wait_hi(1'b0);
        rd(A_L, 33'h0f);
        wr(A_L, 32'h0e);
        rd(A_L, 33'h0e);
        b = $urandom;
        c = $urandom;
        i_fmsp_remote_model.send({1'b0, b});
        i_fmsp_remote_model.send({1'b0, c});
        wait_hi(1'b1);
        rd(A_D, {25'h0, c});
        rd(A_H, 33'h53);
        wr(A_H, 32'h52);
        rd(A_H, 33'h52);
        nbits <= 4'd9;
        for (int k = 0; k < 3; k++) begin
            auto = k < 2;
            odd  = k == 1;
            b    = $urandom;
            wr(A_L, {24'h0, auto, odd, 6'b001010});
            wr(A_H, 32'h9a);
            tx_q.push_back({1'b1, auto ? ^b ^ odd : 1'b1, b});
            wr(A_D, {24'h0, b});
            wait_hi(1'b0);
            repeat (24) @(posedge clk_sys);
        end
        wr(A_L, 32'h8e);
        wr(A_H, 32'hd2);
        b = $urandom;
        i_fmsp_remote_model.send({~^b, b});
        wait_hi(1'b1);
        rd(A_L, 33'h9e);
        rd(A_D, {25'h0, b});
        wr(A_L, 32'h0e);
        wr(A_H, 32'hf2);
        i_fmsp_remote_model.send({1'b0, c});
        repeat (8) @(posedge clk_sys);
        rd(A_H, 33'hf2);
        i_fmsp_remote_model.send({1'b1, b});
        wait_hi(1'b1);
        rd(A_H, 33'hf7);
        rd(A_L, 33'h0e);
        wr(A_H, 32'h00);
        wr(A_L, 32'h00);
        repeat (8) @(posedge clk_sys);
        print_verdict();
    end
endmodule
